// [design/pnc_pkg.sv]
package pnc_pkg;
   // Clock and settle timing
   localparam int CLK_MHZ = 50;
   localparam int SETTLE_TIME_US = 330;
   localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
   localparam int SETTLE_W = 20;

   // Far-end fault constants
   localparam logic [1:0] FAULT_CYCLE_TARGET = 2'h3;
   localparam logic [6:0] FAULT_ONES_PER_CYCLE = 7'h54;

   // Carrier detector constants
   localparam logic [9:0] STREAM_START_MARKER = 10'h311;
   localparam logic [9:0] WINDOW_IDLE = 10'h3ff;
   localparam logic [2:0] SSD_WAIT_BITS = 3'h3;
   localparam logic [2:0] QUIET_BITS = 3'h5;

   // Channel state encoding
   localparam logic [1:0] CH_FAILED = 2'h0;
   localparam logic [1:0] CH_READY = 2'h1;
   localparam logic [1:0] CH_OK = 2'h2;

   // Link permission encoding
   localparam logic [1:0] LC_SCAN = 2'h0;
   localparam logic [1:0] LC_DISABLE = 2'h1;
   localparam logic [1:0] LC_ENABLE = 2'h2;

   // Register map and fields
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam int CTRL_FAULT_EN = 0;
   localparam int CTRL_AN_PRESENT = 1;
   localparam int CTRL_LC_LSB = 2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;

   typedef enum {CD_IDLE, CD_SSD_WAIT, CD_ACTIVE, CD_QUIET} pnc_cd_state_t;
   typedef enum {LM_FAILED, LM_READY, LM_OK} pnc_lm_state_t;
endpackage

// [design/pnc_cd_if.sv]
`timescale 1ns/1ps
interface pnc_cd_if;
   logic code_bit;
   logic carrier;
   logic error;

   // Receive path side feeds bits, reads results
   modport src (
      output code_bit,
      input carrier,
      input error
   );
   // Carrier detector side
   modport det (
      input code_bit,
      output carrier,
      output error
   );
endinterface

// [design/pnc_carrier.sv]
`timescale 1ns/1ps
module pnc_carrier import pnc_pkg::*; (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Decoded bit stream and results
   pnc_cd_if.det cd
);
   logic [9:0] recent_bit_window;
   logic [9:0] next_window;
   pnc_cd_state_t state;
   pnc_cd_state_t next_state;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic next_carrier;
   logic next_error;
   logic trigger;

   ////////////////////////////////////////////////////////////////////////
   // New zero with a one between it and an older zero
   assign trigger = !next_window[0] && next_window[1] &&
                    (next_window[9:2] != 8'hff);

   // Window shift and detector state
   always_comb begin
      next_window = {recent_bit_window[8:0], cd.code_bit};
      next_state = state;
      next_cnt = cnt;
      next_carrier = cd.carrier;
      next_error = cd.error;
      case (state)
         CD_IDLE: begin
            if (trigger) begin
               next_state = CD_SSD_WAIT;
               next_cnt = 3'h0;
               next_carrier = 1'b1;
               next_error = 1'b0;
            end
         end
         CD_SSD_WAIT: begin
            next_cnt = cnt + 3'h1;
            if (next_cnt == SSD_WAIT_BITS) begin
               next_state = CD_ACTIVE;
               next_error = (next_window != STREAM_START_MARKER);
            end
         end
         CD_ACTIVE: begin
            if (next_window == WINDOW_IDLE) begin
               next_state = CD_QUIET;
               next_carrier = 1'b0;
               next_cnt = 3'h0;
            end
         end
         CD_QUIET: begin
            // Holds off retrigger while the idle tail flushes
            next_cnt = cnt + 3'h1;
            if (next_cnt == QUIET_BITS) begin
               next_state = CD_IDLE;
            end
         end
         default: begin
            next_state = CD_IDLE;
         end
      endcase
   end

   // Window starts all ones so no false carrier after reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         recent_bit_window <= WINDOW_IDLE;
         state <= CD_IDLE;
         cnt <= 3'h0;
         cd.carrier <= 1'b0;
         cd.error <= 1'b0;
      end else begin
         recent_bit_window <= next_window;
         state <= next_state;
         cnt <= next_cnt;
         cd.carrier <= next_carrier;
         cd.error <= next_error;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence quiet_entry;
      state == CD_ACTIVE && next_window == WINDOW_IDLE;
   endsequence
   sequence quiet_hold;
      (state == CD_QUIET) [*5];
   endsequence

   chk_window_shift: assert property (
      $past(hresetn) |->
      recent_bit_window == {$past(recent_bit_window[8:0]), $past(cd.code_bit)})
      else $error("window did not shift in newest bit");
   chk_carrier_on: assert property (
      state == CD_IDLE && trigger |=> cd.carrier && state == CD_SSD_WAIT)
      else $error("carrier missed two separated zeros");
   chk_ssd_check: assert property (
      state == CD_SSD_WAIT ##1 state == CD_ACTIVE |->
      cd.error == (recent_bit_window != STREAM_START_MARKER))
      else $error("start marker verdict wrong");
   chk_quiet_five: assert property (
      quiet_entry |=> quiet_hold ##1 state == CD_IDLE)
      else $error("quiet state not five bits long");
   chk_carrier_off: assert property (
      quiet_entry |=> !cd.carrier)
      else $error("carrier held after ten ones");
endmodule

// [design/pnc_top.sv]
`timescale 1ns/1ps
// Function
// - Without fault option remote fault is false; with it, fault forces failed.
// - Without auto-negotiation, link permission always reads as enable.
// - Channel state takes three values: failed, ready and ok.
// - Ten-bit recent window, bit 0 newest, bit 9 oldest.
// - Each received bit shifts window up and enters at bit 0.
// - Settle timer has a fixed length between 330 and 1000 us.
// - Fault cycle count clears on reset or disqualify, saturates at target.
// - Generator counts ones sent per fault cycle, never above 84.
// - Detector counts received ones, clears on zero or disqualify.
// - Each client bit, or generator output, is NRZI encoded to medium.
// - Each medium bit is decoded and sent to client and detector.
// - Carrier turns on at two separated zeros within ten bits.
// - New carrier flags error unless it starts with 1100010001.
// - Ten consecutive ones turn carrier off.
// - Carrier detect with its indications is always built in.
// - Five-bit state lasts exactly five received bits.
// - Fault cycle target is three cycles.
// - Each fault cycle is 84 ones then one zero.
// - Failed on signal loss or disable; ready after settle period.
// - Generator passes client bits with signal, sends fault cycles without.
module pnc_top import pnc_pkg::*; #(
   parameter int unsigned SETTLE_CYCLES_P = SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   // Client side
   input wire logic tx_code_bit,
   output logic rx_code_bit,
   output logic carrier_present,
   output logic carrier_error_flag,
   output logic [1:0] channel_state,
   // Medium transceiver side
   input wire logic rx_nrzi_pin,
   input wire logic medium_signal_ok,
   output logic tx_nrzi
);
   logic [2:0] rx_sync;
   logic [2:0] ok_sync;
   logic rx_level;
   logic next_rx_level;
   logic sig_ok;
   logic next_sig_ok;
   logic prev_level;
   logic next_rx_code_bit;
   logic [6:0] det_ones;
   logic [6:0] next_det_ones;
   logic [1:0] fault_cycle_count;
   logic [1:0] next_fault_cycle_count;
   logic [6:0] gen_ones;
   logic [6:0] next_gen_ones;
   logic transmit_bit_to_serializer;
   logic next_tx_nrzi;
   logic faulting;
   logic remote_fault_seen;
   logic [1:0] link_permission;
   logic fail_cond;
   pnc_lm_state_t lm_state;
   pnc_lm_state_t next_lm_state;
   logic [SETTLE_W-1:0] settle_cnt;
   logic [SETTLE_W-1:0] next_settle_cnt;
   logic [1:0] next_channel_state;
   logic fault_en;
   logic an_present;
   logic [1:0] link_ctrl;
   logic next_fault_en;
   logic next_an_present;
   logic [1:0] next_link_ctrl;
   logic wr_pend;
   logic next_wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] next_wr_addr;
   logic [31:0] next_hrdata;
   logic addr_ok;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; signal ok changes once stages two and three agree.
   // Line data may toggle every clock, so an agree filter would eat it:
   // it takes stage three as is, with the same latency.
   always_comb begin
      next_rx_level = rx_sync[2];
      next_sig_ok = (ok_sync[1] == ok_sync[2]) ? ok_sync[2] : sig_ok;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_sync <= 3'h0;
         ok_sync <= 3'h0;
         rx_level <= 1'b0;
         sig_ok <= 1'b0;
      end else begin
         rx_sync <= {rx_sync[1:0], rx_nrzi_pin};
         ok_sync <= {ok_sync[1:0], medium_signal_ok};
         rx_level <= next_rx_level;
         sig_ok <= next_sig_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive NRZI decode, one code-bit per clock
   assign next_rx_code_bit = rx_level ^ prev_level;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_level <= 1'b0;
         rx_code_bit <= 1'b0;
      end else begin
         prev_level <= rx_level;
         rx_code_bit <= next_rx_code_bit;
      end
   end

   // Carrier detector fed from the same decoded bit as the client
   pnc_cd_if cd_if ();
   assign cd_if.code_bit = rx_code_bit;

   pnc_carrier u_carrier (
      .hclk(hclk),
      .hresetn(hresetn),
      .cd(cd_if.det)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         carrier_present <= 1'b0;
         carrier_error_flag <= 1'b0;
      end else begin
         carrier_present <= cd_if.carrier;
         carrier_error_flag <= cd_if.error;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault detector; first cycle may run long, so ones saturate
   always_comb begin
      next_det_ones = det_ones;
      next_fault_cycle_count = fault_cycle_count;
      if (!sig_ok) begin
         next_det_ones = 7'h0;
         next_fault_cycle_count = 2'h0;
      end else if (rx_code_bit) begin
         if (det_ones != FAULT_ONES_PER_CYCLE) begin
            next_det_ones = det_ones + 7'h1;
         end else begin
            // Overlong run restarts as a possible first cycle
            next_fault_cycle_count = 2'h0;
         end
      end else begin
         next_det_ones = 7'h0;
         if (det_ones != FAULT_ONES_PER_CYCLE) begin
            next_fault_cycle_count = 2'h0;
         end else if (fault_cycle_count != FAULT_CYCLE_TARGET) begin
            next_fault_cycle_count = fault_cycle_count + 2'h1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         det_ones <= 7'h0;
         fault_cycle_count <= 2'h0;
      end else begin
         det_ones <= next_det_ones;
         fault_cycle_count <= next_fault_cycle_count;
      end
   end

   assign faulting = (fault_cycle_count == FAULT_CYCLE_TARGET);
   assign remote_fault_seen = fault_en && faulting;

   ////////////////////////////////////////////////////////////////////////
   // Fault generator and NRZI encode toward the medium
   always_comb begin
      next_gen_ones = 7'h0;
      transmit_bit_to_serializer = tx_code_bit;
      if (fault_en && !sig_ok) begin
         // Cycle of 84 ones, then one zero
         transmit_bit_to_serializer =
            (gen_ones != FAULT_ONES_PER_CYCLE);
         if (gen_ones != FAULT_ONES_PER_CYCLE) begin
            next_gen_ones = gen_ones + 7'h1;
         end
      end
      next_tx_nrzi = tx_nrzi ^ transmit_bit_to_serializer;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gen_ones <= 7'h0;
         tx_nrzi <= 1'b0;
      end else begin
         gen_ones <= next_gen_ones;
         tx_nrzi <= next_tx_nrzi;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link monitor
   assign link_permission = an_present ? link_ctrl : LC_ENABLE;
   assign fail_cond = !sig_ok || link_permission == LC_DISABLE ||
                      remote_fault_seen;

   always_comb begin
      next_lm_state = lm_state;
      next_settle_cnt = 20'h0;
      case (lm_state)
         LM_FAILED: begin
            if (!fail_cond) begin
               next_settle_cnt = settle_cnt + 20'h1;
               if (settle_cnt == SETTLE_W'(SETTLE_CYCLES_P - 1)) begin
                  next_lm_state = LM_READY;
               end
            end
         end
         LM_READY: begin
            if (fail_cond) begin
               next_lm_state = LM_FAILED;
            end else if (link_permission == LC_ENABLE) begin
               next_lm_state = LM_OK;
            end
         end
         LM_OK: begin
            if (fail_cond) begin
               next_lm_state = LM_FAILED;
            end
         end
         default: begin
            next_lm_state = LM_FAILED;
         end
      endcase
      case (next_lm_state)
         LM_READY: next_channel_state = CH_READY;
         LM_OK: next_channel_state = CH_OK;
         default: next_channel_state = CH_FAILED;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lm_state <= LM_FAILED;
         settle_cnt <= 20'h0;
         channel_state <= CH_FAILED;
      end else begin
         lm_state <= next_lm_state;
         settle_cnt <= next_settle_cnt;
         channel_state <= next_channel_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY
   assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;

   always_comb begin
      next_wr_pend = addr_ok && hwrite;
      next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
      next_hrdata = hrdata;
      next_fault_en = fault_en;
      next_an_present = an_present;
      next_link_ctrl = link_ctrl;
      // Read data is fetched in the address phase
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            REG_CTRL: next_hrdata = {28'h0, link_ctrl, an_present, fault_en};
            REG_STATUS: next_hrdata = {25'h0, sig_ok, remote_fault_seen,
                                       faulting, cd_if.error, cd_if.carrier,
                                       channel_state};
            default: next_hrdata = 32'h0;
         endcase
      end
      // Write lands in the data phase
      if (wr_pend && wr_addr == REG_CTRL) begin
         next_fault_en = hwdata[CTRL_FAULT_EN];
         next_an_present = hwdata[CTRL_AN_PRESENT];
         next_link_ctrl = hwdata[CTRL_LC_LSB +: 2];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
         fault_en <= 1'b0;
         an_present <= 1'b0;
         link_ctrl <= LC_SCAN;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
         fault_en <= next_fault_en;
         an_present <= next_an_present;
         link_ctrl <= next_link_ctrl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence settled;
      lm_state == LM_FAILED && !fail_cond &&
      settle_cnt == SETTLE_W'(SETTLE_CYCLES_P - 1);
   endsequence

   chk_fault_off: assert property (
      !fault_en |-> !remote_fault_seen ##1 !remote_fault_seen)
      else $error("remote fault seen with option off");
   chk_fault_fails: assert property (
      remote_fault_seen |=> ##1 channel_state == CH_FAILED)
      else $error("remote fault did not fail channel");
   chk_settle_ready: assert property (
      settled |=> lm_state == LM_READY ##0 channel_state == CH_READY)
      else $error("ready not reached after settle");
   chk_early_ready: assert property (
      lm_state == LM_FAILED && settle_cnt < SETTLE_W'(SETTLE_CYCLES_P - 1)
      |=> lm_state != LM_READY)
      else $error("ready before settle period");
   chk_no_an_ok: assert property (
      !an_present && lm_state == LM_READY && !fail_cond |=> lm_state == LM_OK)
      else $error("permission not treated as enable");
   chk_tx_encode: assert property (
      $past(hresetn) |->
      (tx_nrzi != $past(tx_nrzi)) == $past(transmit_bit_to_serializer))
      else $error("nrzi encode mismatch");
   chk_rx_decode: assert property (
      ##1 rx_code_bit == ($past(rx_level) ^ $past(prev_level)))
      else $error("nrzi decode mismatch");
   chk_cycle_sat: assert property (
      fault_cycle_count == FAULT_CYCLE_TARGET && sig_ok && !rx_code_bit &&
      det_ones == FAULT_ONES_PER_CYCLE |=> fault_cycle_count ==
      FAULT_CYCLE_TARGET)
      else $error("fault cycle count not saturating");
   chk_gen_cycle: assert property (
      fault_en && !sig_ok && gen_ones == FAULT_ONES_PER_CYCLE |->
      !transmit_bit_to_serializer
      ##1 gen_ones == 7'h0)
      else $error("fault cycle zero missing");
   chk_det_ones: assert property (
      sig_ok && !rx_code_bit |=> det_ones == 7'h0)
      else $error("ones count not cleared by zero");
   chk_gen_bound: assert property (
      gen_ones <= FAULT_ONES_PER_CYCLE)
      else $error("generator ones above limit");
endmodule

// [dv/pnc_medium_model.sv]
`timescale 1ns/1ps
module pnc_medium_model (
   // Clock
   input wire logic hclk,
   // Code-bits to put on the line and wanted signal quality
   input wire logic code_bit,
   input wire logic sig_on,
   // Toward the block
   output logic rx_nrzi_pin,
   output logic medium_signal_ok
);
   logic level = 1'b0;
   logic noise = 1'b0;
   logic ok_q = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Line level toggles on a one; noise toggles every cycle
   always @(posedge hclk) begin
      level <= level ^ code_bit;
      noise <= ~noise;
      ok_q <= sig_on;
   end

   // Without signal the line is undefined, so never the last level
   assign rx_nrzi_pin = ok_q ? level : noise;
   assign medium_signal_ok = ok_q;
endmodule

// [dv/tb_pma_nrzi_carrier_detect.sv]
`timescale 1ns/1ps
module tb_pma_nrzi_carrier_detect import pnc_pkg::*;;
   localparam int SETTLE = 20;
   localparam int RX_LAT = 5;
   logic hclk, hresetn, hsel, hwrite, tx_code_bit, code_bit, sig_on;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, hresp, channel_state;
   logic [2:0] hsize;
   logic hreadyout, rx_code_bit, carrier_present, carrier_error_flag;
   logic rx_nrzi_pin, medium_signal_ok, tx_nrzi;
   logic tx_exp, nrzi_prev, tx_chk, rx_chk, col;
   logic sent [$];
   logic txq [$];
   logic [1:0] lc_tab [3] = '{LC_DISABLE, LC_SCAN, LC_ENABLE};
   logic [1:0] st_tab [3] = '{CH_FAILED, CH_READY, CH_OK};
   int mismatches, n_checks, z;

   ////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   pnc_top #(.SETTLE_CYCLES_P(SETTLE)) i_dut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .tx_code_bit(tx_code_bit), .rx_code_bit(rx_code_bit),
      .carrier_present(carrier_present),
      .carrier_error_flag(carrier_error_flag),
      .channel_state(channel_state), .rx_nrzi_pin(rx_nrzi_pin),
      .medium_signal_ok(medium_signal_ok), .tx_nrzi(tx_nrzi));

   pnc_medium_model i_medium (.hclk(hclk), .code_bit(code_bit),
      .sig_on(sig_on), .rx_nrzi_pin(rx_nrzi_pin),
      .medium_signal_ok(medium_signal_ok));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      if (mismatches == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Every step moves the client stream on with a fresh random bit; the waits inside ahb hold it
   task automatic step(input int n);
      repeat (n) begin
         @(posedge hclk);
         tx_code_bit <= 1'($urandom_range(1, 0));
      end
   endtask

   task automatic send(input logic [31:0] pat, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         code_bit <= pat[i];
         step(1);
      end
   endtask

   // Single AHB transfer; no wait count assumed
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      r = hrdata;
      check("hresp", {30'h0, hresp}, {30'h0, HRESP_OKAY});
   endtask

   task automatic wait_state(input logic [1:0] s);
      int n;
      n = 0;
      while (channel_state !== s && n < 200) begin
         step(1);
         n++;
      end
      check("channel_state", {30'h0, channel_state}, {30'h0, s});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Stream monitors: tx decoded by hand, rx against bits sent earlier
   always @(posedge hclk) begin
      tx_exp = tx_code_bit;
      sent.push_back(code_bit);
      if (sent.size() > 16) begin
         void'(sent.pop_front());
      end
   end

   always @(negedge hclk) begin
      if (tx_chk) begin
         check("tx_bit", {31'h0, tx_nrzi ^ nrzi_prev}, {31'h0, tx_exp});
      end
      if (col) begin
         txq.push_back(tx_nrzi ^ nrzi_prev);
      end
      nrzi_prev = tx_nrzi;
      if (rx_chk) begin
         check("rx_bit", {31'h0, rx_code_bit}, {31'h0, sent[15 - RX_LAT]});
      end
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32));
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, sig_on} = '0;
      {tx_code_bit, tx_chk, rx_chk, col, nrzi_prev} = '0;
      hsize = 3'h2;
      code_bit = 1'b1;
      mismatches = 0;
      n_checks = 0;
      step(6);
      check("rst_tx", {31'h0, tx_nrzi}, 32'h0);
      check("rst_car", {31'h0, carrier_present}, 32'h0);
      check("rst_rdy", {31'h0, hreadyout}, 32'h1);
      hresetn <= 1'b1;
      ahb(1'b0, REG_CTRL, 32'h0, rd);
      check("ctrl_rst", rd, 32'h0);
      ahb(1'b0, 8'h40, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      tx_chk = 1'b1;
      // Link comes up only after the settle time
      sig_on <= 1'b1;
      step(10);
      check("early", {30'h0, channel_state}, {30'h0, CH_FAILED});
      wait_state(CH_OK);
      // Random receive stream, then idle turns carrier off
      send(32'hffffffff, 32);
      rx_chk = 1'b1;
      repeat (8) send($urandom, 32);
      rx_chk = 1'b0;
      send(32'hffffffff, 32);
      check("car_off", {31'h0, carrier_present}, 32'h0);
      // Adjacent zeros only are no carrier
      send(32'hffff9fff, 32);
      check("no_car", {31'h0, carrier_present}, 32'h0);
      // Good start marker, bad start, then good again
      send(10'h311, 10);
      send(32'haaaaaaaa, 32);
      check("car_on", {31'h0, carrier_present}, 32'h1);
      check("err_no", {31'h0, carrier_error_flag}, 32'h0);
      send(32'hffffffff, 32);
      check("car_off2", {31'h0, carrier_present}, 32'h0);
      send(32'hffffaaaa, 32);
      check("err_yes", {31'h0, carrier_error_flag}, 32'h1);
      send(32'hffffffff, 32);
      send(10'h311, 10);
      send(32'haaaaaaaa, 32);
      check("err_clr", {31'h0, carrier_error_flag}, 32'h0);
      send(32'hffffffff, 32);
      // Link control codes with negotiation present
      for (int i = 0; i < 3; i++) begin
         ahb(1'b1, REG_CTRL, {28'h0, lc_tab[i], 2'b10}, rd);
         wait_state(st_tab[i]);
      end
      // Fault cycles sent while the signal is lost
      ahb(1'b1, REG_CTRL, 32'h1, rd);
      tx_chk = 1'b0;
      sig_on <= 1'b0;
      wait_state(CH_FAILED);
      col = 1'b1;
      step(300);
      col = 1'b0;
      z = 0;
      while (z < txq.size() && txq[z] !== 1'b0) begin
         z++;
      end
      for (int i = 1; i <= 170; i++) begin
         check("fault_bit", {31'h0, txq[z+i]}, (i % 85 == 0) ? 0 : 1);
      end
      sig_on <= 1'b1;
      step(10);
      tx_chk = 1'b1;
      wait_state(CH_OK);
      // Far-end fault seen only after three full cycles
      send(32'haaaaaaaa, 32);
      repeat (2) begin
         send(32'hffffffff, 32);
         send(32'hffffffff, 32);
         send(21'h1ffffe, 21);
      end
      send(32'hffffffff, 30);
      ahb(1'b0, REG_STATUS, 32'h0, rd);
      check("two_cycles", {31'h0, rd[4]}, 32'h0);
      send(32'hffffffff, 32);
      send(32'hffffffff, 20);
      send(32'h0, 1);
      send(32'hffffffff, 20);
      ahb(1'b0, REG_STATUS, 32'h0, rd);
      check("faulting", {26'h0, rd[5:4]}, 32'h3);
      check("fault_fail", {30'h0, rd[1:0]}, {30'h0, CH_FAILED});
      // Fourth full cycle: count must hold at three, not wrap
      send(32'hffffffff, 32);
      send(32'h7ffffffe, 31);
      send(32'hffffffff, 10);
      ahb(1'b0, REG_STATUS, 32'h0, rd);
      check("fault_sat", {31'h0, rd[4]}, 32'h1);
      send(32'haaaaaaaa, 32);
      ahb(1'b0, REG_STATUS, 32'h0, rd);
      check("fault_clr", {31'h0, rd[4]}, 32'h0);
      tally_and_finish();
   end
endmodule
